// *** include/fesb_regs.vh ***
/*
 * Register map and field positions of the feature error status bank.
 * Assumes the includer works in byte offsets from the control register base.
 * Field positions use the documented numbering (0 = msb); fesb_bit() maps them.
 */
`ifndef FESB_REGS_VH
`define FESB_REGS_VH

`define FESB_ADDR_W          12
`define FESB_OFS_ERR_HIGH    12'h640
`define FESB_OFS_ERR_LOW     12'h644
`define FESB_RST_ERR_HIGH    32'h00000000
`define FESB_RST_ERR_LOW     32'h00000000

`define FESB_POS_BRIGHTNESS  0
`define FESB_POS_WHITE_BAL   3
`define FESB_POS_SHUTTER     7
`define FESB_POS_GAIN        8
`define FESB_POS_TRIGGER     12

`define FESB_FEAT_BRIGHTNESS 3'h0
`define FESB_FEAT_WHITE_BAL  3'h1
`define FESB_FEAT_SHUTTER    3'h2
`define FESB_FEAT_GAIN       3'h3
`define FESB_FEAT_TRIGGER    3'h4
`define FESB_NUM_FEAT        5

`endif

// *** design/fesb_range_check.v ***
/*
 * One feature's out-of-range flag.
 * Assumes value_in and write_stb come from logic on the same clock.
 */
`timescale 1ns/1ps
module fesb_range_check #(
   parameter VAL_W = 12,
   parameter [VAL_W-1:0] MIN_VAL = 12'h000,
   parameter [VAL_W-1:0] MAX_VAL = 12'hFFF
) (
   // clock and reset
   input  wire             clock,
   input  wire             rst_b,
   // feature write
   input  wire             write_stb,
   input  wire [VAL_W-1:0] value_in,
   // flag
   output reg              err_q
);
   reg err_d;

   always @*
   begin
      err_d = err_q;
      if (write_stb)
      begin
         err_d = (value_in < MIN_VAL) || (value_in > MAX_VAL);
      end
   end

   always @(posedge clock)
   begin
      if (!rst_b)
         err_q <= 1'b0;
      else
         err_q <= err_d;
   end
endmodule // fesb_range_check

// *** design/fesb_bank.v ***
/*
 * Feature control error status bank: two read-only status words, one range
 * flag per checked feature, and the pass-through of every feature setting.
 * Assumes the camera's register block presents each feature control write as a
 * one-cycle strobe with the written value field, and reads as addr + rd_stb,
 * all on this block's clock, so no input is synchronised here.
 * Assumes the capture path consumes set_stb_q, set_sel_q and set_value_q.
 */
// Operation
// - each feature control register has one status bit, one meaning error and zero meaning none.
// - a feature's status bit is re-evaluated on every write of its control register.
// - the bit is set when the written setting is below the minimum or above the maximum.
// - capture carries on with an out-of-range setting, which is passed on unchanged.
// - brightness error is read-only bit 0 of the high status word at 0x640.
// - white balance error is read-only bit 3 of the high word, meaningful on the colour variant.
// - shutter error is read-only bit 7 of the high word.
// - gain error is read-only bit 8 of the high word.
// - trigger mode error is read-only bit 12 of the high word.
// - the low status word at 0x644 has no active flags.
// - bit 0 is the most significant bit of each 32-bit word.
`timescale 1ns/1ps
`include "fesb_regs.vh"
module fesb_bank #(
   parameter VAL_W      = 12,
   parameter COLOR      = 1,
   parameter [VAL_W-1:0] BRI_MIN = 12'h000,
   parameter [VAL_W-1:0] BRI_MAX = 12'h0FF,
   parameter [VAL_W-1:0] WB_MIN  = 12'h000,
   parameter [VAL_W-1:0] WB_MAX  = 12'h0FF,
   parameter [VAL_W-1:0] SHT_MIN = 12'h001,
   parameter [VAL_W-1:0] SHT_MAX = 12'hFFF,
   parameter [VAL_W-1:0] GN_MIN  = 12'h15E,
   parameter [VAL_W-1:0] GN_MAX  = 12'h3FF,
   parameter [VAL_W-1:0] TRG_MIN = 12'h000,
   parameter [VAL_W-1:0] TRG_MAX = 12'h001
) (
   // clock and reset
   input  wire                   clock,
   input  wire                   rst_b,
   // feature control writes
   input  wire                   feat_wr_stb,
   input  wire [2:0]             feat_sel,
   input  wire [VAL_W-1:0]       feat_value,
   // register read port
   input  wire                   rd_stb,
   input  wire [`FESB_ADDR_W-1:0] rd_addr,
   input  wire                   wr_stb,
   output reg  [31:0]            rd_data_q,
   output reg                    rd_hit_q,
   // settings to the capture path
   output reg                    set_stb_q,
   output reg  [2:0]             set_sel_q,
   output reg  [VAL_W-1:0]       set_value_q
);
   localparam NF = `FESB_NUM_FEAT;
   // limits packed low feature first, so feature g owns slice g
   localparam [VAL_W*NF-1:0] MINS = {TRG_MIN, GN_MIN, SHT_MIN, WB_MIN, BRI_MIN};
   localparam [VAL_W*NF-1:0] MAXS = {TRG_MAX, GN_MAX, SHT_MAX, WB_MAX, BRI_MAX};
   // white balance is only checked on the colour variant
   localparam [NF-1:0] FEAT_EN = (COLOR != 0) ? 5'h1F : 5'h1D;

   wire [NF-1:0] err;
   wire [NF-1:0] err_vis;
   wire          status_wr;
   reg  [31:0] high_word;
   reg  [31:0] rd_data_d;
   reg         rd_hit_d;

   // converts msb-first field number to verilog bit index
   function integer fesb_bit;
      input integer pos;
      begin
         fesb_bit = 31 - pos;
      end
   endfunction

   // one if the offset names one of the two status words
   function fesb_addr_hit;
      input [`FESB_ADDR_W-1:0] addr;
      begin
         case (addr)
            `FESB_OFS_ERR_HIGH:
               fesb_addr_hit = 1'b1;
            `FESB_OFS_ERR_LOW:
               fesb_addr_hit = 1'b1;
            default:
               fesb_addr_hit = 1'b0;
         endcase
      end
   endfunction

   assign err_vis = err & FEAT_EN;

   // status writes ignored
   // a write into the status space changes nothing; it only withholds the hit of a read in the same cycle
   assign status_wr = wr_stb && fesb_addr_hit(rd_addr);

   genvar g;
   generate
      for (g = 0; g < NF; g = g + 1)
      begin : g_feat
         localparam [2:0] SEL = g;
         wire sel_wr;
         // selectors 5..7 reach no checker and leave every flag alone
         assign sel_wr = feat_wr_stb && (feat_sel == SEL);
         fesb_range_check #(
            .VAL_W   (VAL_W),
            .MIN_VAL (MINS[VAL_W*g +: VAL_W]),
            .MAX_VAL (MAXS[VAL_W*g +: VAL_W])
         ) u_chk (
            .clock     (clock),
            .rst_b     (rst_b),
            .write_stb (sel_wr),
            .value_in  (feat_value),
            .err_q     (err[g])
         );
      end
   endgenerate

   always @*
   begin
      high_word = `FESB_RST_ERR_HIGH;
      high_word[fesb_bit(`FESB_POS_BRIGHTNESS)] = err_vis[`FESB_FEAT_BRIGHTNESS];
      high_word[fesb_bit(`FESB_POS_WHITE_BAL)]  = err_vis[`FESB_FEAT_WHITE_BAL];
      high_word[fesb_bit(`FESB_POS_SHUTTER)]    = err_vis[`FESB_FEAT_SHUTTER];
      high_word[fesb_bit(`FESB_POS_GAIN)]       = err_vis[`FESB_FEAT_GAIN];
      high_word[fesb_bit(`FESB_POS_TRIGGER)]    = err_vis[`FESB_FEAT_TRIGGER];
   end

   always @*
   begin
      rd_data_d = 32'h00000000;
      rd_hit_d  = rd_stb && fesb_addr_hit(rd_addr);
      if (rd_stb)
      begin
         case (rd_addr)
            `FESB_OFS_ERR_HIGH:
            begin
               rd_data_d = high_word;
            end
            `FESB_OFS_ERR_LOW:
            begin
               rd_data_d = `FESB_RST_ERR_LOW;
            end
            // unmapped offsets read as zero so a stray read never shows old flags
            default:
            begin
               rd_data_d = 32'h00000000;
            end
         endcase
      end
   end

   // read answers and the setting pass-through share one register stage,
   // so every output comes straight from a flip-flop
   always @(posedge clock)
   begin
      if (!rst_b)
      begin
         rd_data_q   <= 32'h00000000;
         rd_hit_q    <= 1'b0;
         set_stb_q   <= 1'b0;
         set_sel_q   <= 3'h0;
         set_value_q <= {VAL_W{1'b0}};
      end
      else
      begin
         rd_data_q   <= rd_data_d;
         rd_hit_q    <= rd_hit_d && !status_wr;
         set_stb_q   <= feat_wr_stb;
         set_sel_q   <= feat_sel;
         set_value_q <= feat_value;
      end
   end
endmodule // fesb_bank

// *** tb/fesb_props.sv ***
/* port checker for fesb_bank; assumes default range limits and one clock */
`timescale 1ns/1ps
module fesb_props (
   // all design ports
   input wire        clock,
   input wire        rst_b,
   input wire        feat_wr_stb,
   input wire [2:0]  feat_sel,
   input wire [11:0] feat_value,
   input wire        rd_stb,
   input wire [11:0] rd_addr,
   input wire        wr_stb,
   input wire [31:0] rd_data_q,
   input wire        rd_hit_q,
   input wire        set_stb_q,
   input wire [2:0]  set_sel_q,
   input wire [11:0] set_value_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire hr = rd_stb && rd_addr == 12'h640;
   a_pass_thru: assert property (feat_wr_stb |=> set_stb_q && {set_sel_q, set_value_q} ==
      $past({feat_sel, feat_value})) else $error("setting not passed on");
   a_no_stray: assert property (!feat_wr_stb |=> !set_stb_q) else $error("stray setting strobe");
   a_bri_flag: assert property (feat_wr_stb && feat_sel == 3'h0 ##1 hr |=>
      rd_data_q[31] == ($past(feat_value, 2) > 12'h0FF)) else $error("brightness flag wrong");
   a_gain_flag: assert property (feat_wr_stb && feat_sel == 3'h3 ##1 hr |=> rd_data_q[23] ==
      ($past(feat_value, 2) < 12'h15E || $past(feat_value, 2) > 12'h3FF)) else $error("gain flag wrong");
   a_low_word: assert property (rd_stb && rd_addr == 12'h644 && !wr_stb |=> rd_data_q == 32'h0 && rd_hit_q)
      else $error("low word wrong");
   a_unused_bits: assert property (hr |=> (rd_data_q & 32'h6E77FFFF) == 32'h0) else $error("unused bit set");
   a_unmapped_read: assert property (rd_stb && rd_addr != 12'h640 && rd_addr != 12'h644 |=>
      rd_data_q == 32'h0 && !rd_hit_q) else $error("unmapped read answered");
   a_write_ignored: assert property (rd_stb && wr_stb |=> !rd_hit_q) else $error("write answered");
   cover property (feat_wr_stb && feat_sel == 3'h3);
   cover property (hr ##1 rd_data_q != 32'h0);
   cover property (rd_stb && wr_stb);
endmodule // fesb_props
bind fesb_bank fesb_props u_props (.*);

// *** tb/fesb_host.sv ***
/* host model issuing status reads; assumes fesb_bank read port timing */
`timescale 1ns/1ps
module fesb_host (
   // read port
   input  wire        clock,
   input  wire [31:0] rd_data_q,
   input  wire        rd_hit_q,
   output reg         rd_stb = 1'b0,
   output reg  [11:0] rd_addr = 12'h000,
   output reg         wr_stb = 1'b0
);
   task rd(input [11:0] a, input w, output [31:0] d, output h);
   begin
      @(posedge clock);
      rd_stb <= 1'b1;
      rd_addr <= a;
      wr_stb <= w;
      @(posedge clock);
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      rd_addr <= ~a;
      #1;
      d = rd_data_q;
      h = rd_hit_q;
   end
   endtask
endmodule // fesb_host

// *** tb/fesb_bank_tb_top.sv ***
/* bench for fesb_bank at default limits; host model makes the reads */
`timescale 1ns/1ps
module fesb_bank_tb_top;
   reg         clock = 0, rst_b = 0, feat_wr_stb = 0, h;
   reg  [2:0]  feat_sel = 0;
   reg  [11:0] feat_value = 0;
   reg  [31:0] exp_q = 0, d;
   wire        rd_stb, wr_stb, rd_hit_q, set_stb_q;
   wire [11:0] rd_addr, set_value_q;
   wire [2:0]  set_sel_q;
   wire [31:0] rd_data_q;
   integer     error_cnt = 0, n_tests = 0, cyc = 0;
   initial forever #25 clock = ~clock;
   fesb_bank u_dut (.clock(clock), .rst_b(rst_b), .feat_wr_stb(feat_wr_stb), .feat_sel(feat_sel),
      .feat_value(feat_value), .rd_stb(rd_stb), .rd_addr(rd_addr), .wr_stb(wr_stb), .rd_data_q(rd_data_q),
      .rd_hit_q(rd_hit_q), .set_stb_q(set_stb_q), .set_sel_q(set_sel_q), .set_value_q(set_value_q));
   fesb_host u_host (.clock(clock), .rd_data_q(rd_data_q), .rd_hit_q(rd_hit_q), .rd_stb(rd_stb),
      .rd_addr(rd_addr), .wr_stb(wr_stb));
   task chk(input [32:0] g, input [32:0] e);
   begin
      n_tests = n_tests + 1;
      if (g !== e)
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      if (g !== e)
         error_cnt = error_cnt + 1;
   end
   endtask
   task wr(input [2:0] s, input [11:0] v);
   begin
      @(posedge clock);
      feat_wr_stb <= 1'b1;
      feat_sel <= s;
      feat_value <= v;
      @(posedge clock);
      feat_wr_stb <= 1'b0;
      #1;
      chk({set_stb_q, set_sel_q, set_value_q}, {1'b1, s, v});
   end
   endtask
   task t_ranges;
      reg [11:0] lo, hi, v;
      integer f, k;
   begin
      for (f = 0; f < 20; f = f + 1)
      begin
         k = f / 4;
         {lo, hi} = k == 2 ? 24'h001FFF : k == 3 ? 24'h15E3FF : k == 4 ? 24'h000001 : 24'h0000FF;
         v = f % 4 == 0 ? lo - 1 : f % 4 == 1 ? lo : f % 4 == 2 ? hi : hi + 1;
         wr(k[2:0], v);
         exp_q[k == 0 ? 31 : k == 1 ? 28 : k == 2 ? 24 : k == 3 ? 23 : 19] = v < lo || v > hi;
         u_host.rd(12'h640, 1'b0, d, h);
         chk({d, h}, {exp_q, 1'b1});
      end
      $display("t_ranges done");
   end
   endtask
   task t_reset;
   begin
      wr(3'h3, 12'h000);
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      exp_q = 32'h00000000;
      u_host.rd(12'h640, 1'b0, d, h);
      chk({d, h}, {exp_q, 1'b1});
      $display("t_reset done");
   end
   endtask
   task t_misc;
   begin
      wr(3'h5, 12'hFFF);
      u_host.rd(12'h640, 1'b1, d, h);
      chk({d, h}, {exp_q, 1'b0});
      u_host.rd(12'h644, 1'b0, d, h);
      chk({d, h}, 33'h1);
      u_host.rd(12'h648, 1'b0, d, h);
      chk({d, h}, 33'h0);
      $display("t_misc done");
   end
   endtask
   task tally_and_finish;
   begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      t_ranges;
      t_reset;
      t_misc;
      tally_and_finish;
   end
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 1000)
      begin
         error_cnt = error_cnt + 1;
         tally_and_finish;
      end
   end
endmodule // fesb_bank_tb_top
